/* File: rtl/vih_pkg.sv */
package vih_pkg;
    localparam logic [1:0] EL1 = 2'h1;
    localparam logic [1:0] EL2 = 2'h2;
    localparam logic [1:0] EL3 = 2'h3;
    // hypervisor-level encodings
    localparam logic [2:0] OP1_HYP = 3'h4;
    localparam logic [3:0] CRN_IRQ = 4'hC;
    localparam logic [3:0] CRM_AP0 = 4'h8;
    localparam logic [3:0] CRM_AP1 = 4'h9;
    localparam logic [3:0] CRM_CTL = 4'hB;
    localparam logic [3:0] CRM_LR = 4'hC;
    localparam logic [2:0] OP2_AP = 3'h0;
    localparam logic [2:0] OP2_HCR = 3'h0;
    localparam logic [2:0] OP2_VTR = 3'h1;
    localparam logic [2:0] OP2_VMCR = 3'h7;
    localparam logic [2:0] LR_OP2_END = 3'h4;
    localparam int LR_NUM = 4;
    // guest-level encodings, used for trap classification
    localparam logic [2:0] OP1_GUEST = 3'h0;
    localparam logic [3:0] GCRM_GRP0 = 4'h8;
    localparam logic [3:0] GCRM_GRP1 = 4'h9;
    localparam logic [3:0] GCRM_CTL = 4'hC;
    localparam logic [2:0] GOP2_BPR1 = 3'h3;
    localparam logic [2:0] GOP2_CTLR = 3'h4;
    localparam logic [3:0] GCRM_DIR = 4'hB;
    localparam logic [2:0] GOP2_DIR = 3'h1;
    // control register fields
    localparam int HCR_CNT_LSB = 27;
    localparam int HCR_DEACTIVATE_WRITE_TRAP = 14;
    localparam int HCR_SYSTEM_ERROR_TRAP = 13;
    localparam int HCR_GROUP1_ACCESS_TRAP = 12;
    localparam int HCR_GROUP0_ACCESS_TRAP = 11;
    localparam int HCR_TC = 10;
    localparam int HCR_V1D = 7;
    localparam int HCR_V1E = 6;
    localparam int HCR_V0D = 5;
    localparam int HCR_V0E = 4;
    localparam int HCR_NO_PENDING_MAINT_EN = 3;
    localparam int HCR_LRENP = 2;
    localparam int HCR_UIE = 1;
    localparam int HCR_EN = 0;
    localparam logic [31:0] HCR_WMASK = 32'h00005CFF;
    localparam logic [31:0] HCR_RST = 32'h00000000;
    localparam logic [4:0] CNT_RST = 5'h00;
    localparam logic [31:0] AP_RST = 32'h00000000;
    // machine control register
    localparam int VMCR_VIRTUAL_GROUP0_ENABLE = 0;
    localparam int VMCR_VIRTUAL_GROUP1_ENABLE = 1;
    localparam logic [31:0] VMCR_WMASK = 32'hFFFC0213;
    localparam logic [31:0] VMCR_FIXED = 32'h00000008;
    localparam logic [31:0] VMCR_RST = 32'h004C0000;
    // type register
    localparam logic [31:0] VTR_VALUE = 32'h90280003;
    localparam logic [31:0] VTR_NO_HYP = 32'h00100000;
    localparam logic [4:0] VTR_LR_CNT = 5'h03;
    // list entry state bits
    localparam int LR_PEND_BIT = 28;
    localparam int LR_ACT_BIT = 29;
    localparam logic [31:0] LR_RST = 32'h00000000;
    // active-priority bit n stands for priority n * 8
    localparam int PRIO_LSB = 3;
    typedef enum {REG_NONE, REG_AP0, REG_AP1, REG_HCR, REG_VTR, REG_VMCR, REG_LR} vih_reg_e;
    typedef enum {G_NONE, G_GRP0, G_GRP1, G_COMMON, G_DIR} vih_gcls_e;
endpackage

/* File: rtl/vih_prio_if.sv */
`timescale 1ns/1ps
interface vih_prio_if;
    logic wr;
    logic [31:0] wdata;
    logic set;
    logic [4:0] set_idx;
    logic drop;
    logic [31:0] value;
    modport ctrl (output wr, output wdata, output set, output set_idx, output drop,
                  input value);
    modport trk (input wr, input wdata, input set, input set_idx, input drop,
                 output value);
endinterface

/* File: rtl/vih_prio_track.sv */
`timescale 1ns/1ps
module vih_prio_track (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    vih_prio_if.trk prio
);
    logic [31:0] act_q;
    logic [31:0] act_d;

    always_comb begin
        act_d = act_q;
        if (prio.wr) begin
            act_d = prio.wdata;
        end
        // lowest set bit is the highest active priority, dropped first
        if (prio.drop) begin
            act_d = act_d & (act_d - 32'h00000001);
        end
        // activation wins over a same-cycle drop or write
        if (prio.set) begin
            act_d = act_d | (32'h00000001 << prio.set_idx);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            act_q <= vih_pkg::AP_RST;
        end else begin
            act_q <= act_d;
        end
    end

    assign prio.value = act_q;

    a_ap_reset_zero: assert property (@(posedge clk_sys_i) !rst_n_i |=> prio.value == 32'h00000000)
        else $error("active priorities not cleared by reset");
    a_ap_set_bit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        prio.set |=> prio.value[$past(prio.set_idx)])
        else $error("activated priority bit not recorded");
endmodule

/* File: rtl/vih_ctrl.sv */
`timescale 1ns/1ps
// Functional notes
// - active bit n means priority n times 8
// - both active-priority registers reset to zero
// - no hypervisor level: group1 priorities read zero
// - exactly four list entries, selector 0-3
// - other list entry selectors are undefined
// - deactivate-write trap bit traps guest deactivates
// - system error trap bit fixed zero
// - group1 trap bit traps guest group1 accesses
// - group0 trap bit traps guest group0 accesses
// - common trap bit traps guest common accesses
// - maintenance when group1 disabled and enabled
// - maintenance when group1 enabled and enabled
// - maintenance when group0 disabled and enabled
// - maintenance when group0 enabled and enabled
// - maintenance while no entry is pending
// - deactivate count; maintenance while count nonzero
// - maintenance while at most one valid entry
// - enable bit gates the virtual interface
// - group1 enable is machine control bit 1
// - group0 enable is machine control bit 0
// - type register reports entry count minus one; count field reads zero without hypervisor level
module vih_ctrl #(
    parameter bit EL2_PRESENT = 1'b1
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic [1:0] acc_el_i,
    input wire logic acc_ns_i,
    input wire logic [2:0] acc_op1_i,
    input wire logic [3:0] acc_crn_i,
    input wire logic [3:0] acc_crm_i,
    input wire logic [2:0] acc_op2_i,
    input wire logic [31:0] acc_wdata_i,
    input wire logic act_valid_i,
    input wire logic act_grp1_i,
    input wire logic [7:0] act_prio_i,
    input wire logic drop_valid_i,
    input wire logic drop_grp1_i,
    input wire logic eoi_miss_i,
    output logic acc_done_o,
    output logic [31:0] acc_rdata_o,
    output logic acc_undef_o,
    output logic acc_trap_o,
    output logic virt_if_enable_o,
    output logic maint_irq_o
);
    vih_pkg::vih_reg_e sel;
    vih_pkg::vih_gcls_e gcls;
    logic hyp_sel;
    logic guest_sel;
    logic priv_ok;
    logic undef_c;
    logic trap_c;
    logic wr_ok;
    logic [31:0] hcr_q;
    logic [4:0] cnt_q;
    logic [31:0] vmcr_q;
    logic [31:0] lr_q [vih_pkg::LR_NUM];
    logic [1:0] lr_idx;
    logic [31:0] rdata_c;
    logic no_pend;
    logic [2:0] valid_cnt;
    logic maint_d;
    logic maint_q;
    logic done_q;
    logic undef_q;
    logic trap_q;
    logic [31:0] rdata_q;
    logic en;

    vih_prio_if ap0_if ();
    vih_prio_if ap1_if ();

    assign hyp_sel = acc_op1_i == vih_pkg::OP1_HYP && acc_crn_i == vih_pkg::CRN_IRQ;
    assign guest_sel = acc_op1_i == vih_pkg::OP1_GUEST && acc_crn_i == vih_pkg::CRN_IRQ;
    assign priv_ok = acc_el_i == vih_pkg::EL3 || (acc_el_i == vih_pkg::EL2 && EL2_PRESENT);
    assign lr_idx = acc_op2_i[1:0];
    assign en = hcr_q[vih_pkg::HCR_EN];

    always_comb begin
        sel = vih_pkg::REG_NONE;
        if (!hyp_sel) begin
            sel = vih_pkg::REG_NONE;
        end else if (acc_crm_i == vih_pkg::CRM_AP0 && acc_op2_i == vih_pkg::OP2_AP) begin
            sel = vih_pkg::REG_AP0;
        end else if (acc_crm_i == vih_pkg::CRM_AP1 && acc_op2_i == vih_pkg::OP2_AP) begin
            sel = vih_pkg::REG_AP1;
        end else if (acc_crm_i == vih_pkg::CRM_CTL && acc_op2_i == vih_pkg::OP2_HCR) begin
            sel = vih_pkg::REG_HCR;
        end else if (acc_crm_i == vih_pkg::CRM_CTL && acc_op2_i == vih_pkg::OP2_VTR) begin
            sel = vih_pkg::REG_VTR;
        end else if (acc_crm_i == vih_pkg::CRM_CTL && acc_op2_i == vih_pkg::OP2_VMCR) begin
            sel = vih_pkg::REG_VMCR;
        end else if (acc_crm_i == vih_pkg::CRM_LR && acc_op2_i < vih_pkg::LR_OP2_END) begin
            sel = vih_pkg::REG_LR;
        end
    end

    always_comb begin
        gcls = vih_pkg::G_NONE;
        if (!guest_sel) begin
            gcls = vih_pkg::G_NONE;
        end else if (acc_crm_i == vih_pkg::GCRM_GRP0) begin
            gcls = vih_pkg::G_GRP0;
        end else if (acc_crm_i == vih_pkg::GCRM_GRP1) begin
            gcls = vih_pkg::G_GRP1;
        end else if (acc_crm_i == vih_pkg::GCRM_CTL && acc_op2_i == vih_pkg::GOP2_BPR1) begin
            gcls = vih_pkg::G_GRP1;
        end else if (acc_crm_i == vih_pkg::GCRM_CTL && acc_op2_i == vih_pkg::GOP2_CTLR) begin
            gcls = vih_pkg::G_COMMON;
        end else if (acc_crm_i == vih_pkg::GCRM_DIR && acc_op2_i == vih_pkg::GOP2_DIR) begin
            gcls = vih_pkg::G_DIR;
        end
    end

    // unknown hypervisor encodings, including list selectors past the fourth
    assign undef_c = acc_valid_i && ((hyp_sel && (sel == vih_pkg::REG_NONE || !priv_ok))
                     || (!hyp_sel && !guest_sel));

    // only non-secure guest-kernel accesses are ever trapped
    always_comb begin
        trap_c = 1'b0;
        if (acc_valid_i && acc_el_i == vih_pkg::EL1 && acc_ns_i) begin
            trap_c = (gcls == vih_pkg::G_GRP0 && hcr_q[vih_pkg::HCR_GROUP0_ACCESS_TRAP])
                  || (gcls == vih_pkg::G_GRP1 && hcr_q[vih_pkg::HCR_GROUP1_ACCESS_TRAP])
                  || (gcls == vih_pkg::G_COMMON && hcr_q[vih_pkg::HCR_TC])
                  || (gcls == vih_pkg::G_DIR && acc_write_i && hcr_q[vih_pkg::HCR_DEACTIVATE_WRITE_TRAP]);
        end
    end

    assign wr_ok = acc_valid_i && acc_write_i && hyp_sel && !undef_c;

    // write mask keeps the system error trap bit at zero
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            hcr_q <= vih_pkg::HCR_RST;
        end else if (wr_ok && sel == vih_pkg::REG_HCR) begin
            hcr_q <= acc_wdata_i & vih_pkg::HCR_WMASK;
        end
    end

    // a missed deactivate in the write cycle still counts
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cnt_q <= vih_pkg::CNT_RST;
        end else if (wr_ok && sel == vih_pkg::REG_HCR) begin
            cnt_q <= acc_wdata_i[31:27] + {4'h0, eoi_miss_i};
        end else if (eoi_miss_i) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            vmcr_q <= vih_pkg::VMCR_RST;
        end else if (wr_ok && sel == vih_pkg::REG_VMCR) begin
            vmcr_q <= acc_wdata_i & vih_pkg::VMCR_WMASK;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < vih_pkg::LR_NUM; i++) begin
                lr_q[i] <= vih_pkg::LR_RST;
            end
        end else if (wr_ok && sel == vih_pkg::REG_LR) begin
            lr_q[lr_idx] <= acc_wdata_i;
        end
    end

    // active-priority trackers; hardware events only while enabled
    assign ap0_if.wr = wr_ok && sel == vih_pkg::REG_AP0;
    assign ap1_if.wr = wr_ok && sel == vih_pkg::REG_AP1 && EL2_PRESENT;
    assign ap0_if.wdata = acc_wdata_i;
    assign ap1_if.wdata = acc_wdata_i;
    assign ap0_if.set = act_valid_i && !act_grp1_i && en;
    assign ap1_if.set = act_valid_i && act_grp1_i && en && EL2_PRESENT;
    assign ap0_if.set_idx = act_prio_i[7:vih_pkg::PRIO_LSB];
    assign ap1_if.set_idx = act_prio_i[7:vih_pkg::PRIO_LSB];
    assign ap0_if.drop = drop_valid_i && !drop_grp1_i && en;
    assign ap1_if.drop = drop_valid_i && drop_grp1_i && en && EL2_PRESENT;

    vih_prio_track u_ap0 (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .prio(ap0_if.trk)
    );

    vih_prio_track u_ap1 (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .prio(ap1_if.trk)
    );

    always_comb begin
        case (sel)
            vih_pkg::REG_AP0: rdata_c = ap0_if.value;
            vih_pkg::REG_AP1: rdata_c = EL2_PRESENT ? ap1_if.value : 32'h00000000;
            vih_pkg::REG_HCR: rdata_c = {cnt_q, hcr_q[26:0]};
            vih_pkg::REG_VTR: rdata_c = EL2_PRESENT ? vih_pkg::VTR_VALUE : vih_pkg::VTR_NO_HYP;
            vih_pkg::REG_VMCR: rdata_c = EL2_PRESENT ? (vmcr_q | vih_pkg::VMCR_FIXED) : 32'h00000000;
            vih_pkg::REG_LR: rdata_c = lr_q[lr_idx];
            default: rdata_c = 32'h00000000;
        endcase
    end

    always_comb begin
        no_pend = 1'b1;
        valid_cnt = 3'h0;
        for (int i = 0; i < vih_pkg::LR_NUM; i++) begin
            if (lr_q[i][vih_pkg::LR_PEND_BIT]) begin
                no_pend = 1'b0;
            end
            if (lr_q[i][vih_pkg::LR_PEND_BIT] || lr_q[i][vih_pkg::LR_ACT_BIT]) begin
                valid_cnt = valid_cnt + 3'h1;
            end
        end
    end

    // registered so the line is glitch free; follows conditions one cycle late
    always_comb begin
        maint_d = en && (
            (hcr_q[vih_pkg::HCR_V1D] && !vmcr_q[vih_pkg::VMCR_VIRTUAL_GROUP1_ENABLE])
            || (hcr_q[vih_pkg::HCR_V1E] && vmcr_q[vih_pkg::VMCR_VIRTUAL_GROUP1_ENABLE])
            || (hcr_q[vih_pkg::HCR_V0D] && !vmcr_q[vih_pkg::VMCR_VIRTUAL_GROUP0_ENABLE])
            || (hcr_q[vih_pkg::HCR_V0E] && vmcr_q[vih_pkg::VMCR_VIRTUAL_GROUP0_ENABLE])
            || (hcr_q[vih_pkg::HCR_NO_PENDING_MAINT_EN] && no_pend)
            || (hcr_q[vih_pkg::HCR_LRENP] && cnt_q != 5'h00)
            || (hcr_q[vih_pkg::HCR_UIE] && valid_cnt <= 3'h1));
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            maint_q <= 1'b0;
        end else begin
            maint_q <= maint_d;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            done_q <= 1'b0;
            undef_q <= 1'b0;
            trap_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            done_q <= acc_valid_i;
            undef_q <= undef_c;
            trap_q <= trap_c;
            rdata_q <= (acc_valid_i && !acc_write_i && !undef_c) ? rdata_c : 32'h00000000;
        end
    end

    assign acc_done_o = done_q;
    assign acc_undef_o = undef_q;
    assign acc_trap_o = trap_q;
    assign acc_rdata_o = rdata_q;
    assign virt_if_enable_o = en;
    assign maint_irq_o = maint_q;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_guest_k;
        acc_valid_i && acc_el_i == vih_pkg::EL1 && acc_ns_i && guest_sel;
    endsequence
    sequence s_hyp_read(logic [3:0] crm, logic [2:0] op2);
        acc_valid_i && !acc_write_i && hyp_sel && priv_ok && acc_crm_i == crm
            && acc_op2_i == op2;
    endsequence

    a_lr_range_undef: assert property (
        acc_valid_i && hyp_sel && acc_crm_i == vih_pkg::CRM_LR && acc_op2_i[2] |=>
        acc_done_o && acc_undef_o && acc_rdata_o == 32'h00000000)
        else $error("list selector past four not undefined");
    a_dir_trap: assert property (
        s_guest_k and (acc_write_i && gcls == vih_pkg::G_DIR) |=> acc_trap_o == $past(hcr_q[14]))
        else $error("deactivate write trap wrong");
    a_grp1_trap: assert property (
        s_guest_k and (gcls == vih_pkg::G_GRP1) |=> acc_trap_o == $past(hcr_q[12]))
        else $error("group1 trap wrong");
    a_grp0_trap: assert property (
        s_guest_k and (gcls == vih_pkg::G_GRP0) |=> acc_trap_o == $past(hcr_q[11]))
        else $error("group0 trap wrong");
    a_common_trap: assert property (
        s_guest_k and (gcls == vih_pkg::G_COMMON) |=> acc_trap_o == $past(hcr_q[10]))
        else $error("common trap wrong");
    a_system_error_trap_zero: assert property (
        s_hyp_read(vih_pkg::CRM_CTL, vih_pkg::OP2_HCR) |=> !acc_rdata_o[13])
        else $error("system error trap bit not zero");
    a_vtr_count: assert property (
        s_hyp_read(vih_pkg::CRM_CTL, vih_pkg::OP2_VTR) |=>
        acc_rdata_o[4:0] == (EL2_PRESENT ? vih_pkg::VTR_LR_CNT : 5'h00))
        else $error("entry count field not three");
    a_ap1_absent: assert property (
        (!EL2_PRESENT) and s_hyp_read(vih_pkg::CRM_AP1, vih_pkg::OP2_AP) |=>
        acc_rdata_o == 32'h00000000)
        else $error("group1 priorities visible without hypervisor");
    a_maint_gate: assert property (!en ##1 !en |-> !maint_irq_o)
        else $error("maintenance raised while disabled");
    a_maint_nopend: assert property (
        en && hcr_q[3] && no_pend |=> maint_irq_o)
        else $error("no-pending maintenance missing");
    a_maint_count: assert property (
        en && hcr_q[2] && cnt_q != 5'h00 |=> maint_irq_o)
        else $error("deactivate count maintenance missing");
    a_maint_under: assert property (
        en && hcr_q[1] && valid_cnt <= 3'h1 |=> maint_irq_o)
        else $error("underflow maintenance missing");
    a_maint_grp: assert property (
        en && ((hcr_q[7] && !vmcr_q[1]) || (hcr_q[6] && vmcr_q[1])
        || (hcr_q[5] && !vmcr_q[0]) || (hcr_q[4] && vmcr_q[0])) |=> maint_irq_o)
        else $error("group enable maintenance missing");
    a_maint_idle: assert property (!maint_d |=> !maint_irq_o)
        else $error("maintenance held without cause");
    a_cnt_step: assert property (
        eoi_miss_i && !(wr_ok && sel == vih_pkg::REG_HCR) |=> cnt_q == $past(cnt_q) + 5'h01)
        else $error("deactivate count did not step");
endmodule

/* File: test/vih_core_model.sv */
`timescale 1ns/1ps
module vih_core_model (
    input wire logic clk_sys_i,
    output logic acc_valid_o,
    output logic acc_write_o,
    output logic [1:0] acc_el_o,
    output logic acc_ns_o,
    output logic [2:0] acc_op1_o,
    output logic [3:0] acc_crn_o,
    output logic [3:0] acc_crm_o,
    output logic [2:0] acc_op2_o,
    output logic [31:0] acc_wdata_o,
    output logic act_valid_o,
    output logic act_grp1_o,
    output logic [7:0] act_prio_o,
    output logic drop_valid_o,
    output logic drop_grp1_o,
    output logic eoi_miss_o
);
    initial begin
        {acc_valid_o, acc_write_o, acc_el_o, acc_ns_o, acc_op1_o} = '0;
        {acc_crn_o, acc_crm_o, acc_op2_o, acc_wdata_o} = '0;
        {act_valid_o, act_grp1_o, act_prio_o, drop_valid_o, drop_grp1_o, eoi_miss_o} = '0;
    end
    // one access per call; the answer is settled at the falling edge after the taking edge
    task automatic access(input logic w, input logic [1:0] el, input logic ns,
                          input logic [2:0] op1, input logic [3:0] crm, input logic [2:0] op2,
                          input logic [31:0] d);
        @(negedge clk_sys_i);
        acc_valid_o = 1'b1;
        acc_write_o = w;
        acc_el_o = el;
        acc_ns_o = ns;
        acc_op1_o = op1;
        acc_crn_o = 4'hC;
        acc_crm_o = crm;
        acc_op2_o = op2;
        acc_wdata_o = d;
        @(negedge clk_sys_i);
        acc_valid_o = 1'b0;
        // stale data is inverted so a late sample cannot match by luck
        acc_wdata_o = ~d;
    endtask
    // kind is one-hot: activate, drop, missed deactivate
    task automatic pulse(input logic [2:0] kind, input logic g, input logic [7:0] p);
        @(negedge clk_sys_i);
        act_valid_o = kind[0];
        act_grp1_o = g;
        act_prio_o = p;
        drop_valid_o = kind[1];
        drop_grp1_o = g;
        eoi_miss_o = kind[2];
        @(negedge clk_sys_i);
        act_valid_o = 1'b0;
        drop_valid_o = 1'b0;
        eoi_miss_o = 1'b0;
        act_prio_o = ~p;
    endtask
endmodule

/* File: test/vih_ctrl_tb_top.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
    end \
end
module vih_ctrl_tb_top;
    logic clk_sys_i, rst_n_i;
    logic acc_valid, acc_write, acc_ns, act_valid, act_grp1, drop_valid, drop_grp1, eoi_miss;
    logic [1:0] acc_el;
    logic [2:0] acc_op1, acc_op2;
    logic [3:0] acc_crn, acc_crm;
    logic [31:0] acc_wdata, rdata, r_data, m_ap0, m_ap1, m_hcr, m_vmcr, nh_rdata, r_nh;
    logic [7:0] act_prio;
    logic done, undef, trap, virt_en, maint, r_undef, r_trap;
    logic [31:0] m_lr [4];
    logic [3:0] t_crm [9] = '{4'h8, 4'h9, 4'hB, 4'hB, 4'hB, 4'hC, 4'hC, 4'hC, 4'hC};
    logic [2:0] t_op2 [9] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h7, 3'h0, 3'h1, 3'h2, 3'h3};
    logic [3:0] g_crm [4] = '{4'h8, 4'h9, 4'hC, 4'hB};
    logic [2:0] g_op2 [4] = '{3'h4, 3'h0, 3'h4, 3'h1};
    int g_bit [4] = '{11, 12, 10, 14};
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 91649;
    int idx;
    vih_core_model core (.clk_sys_i(clk_sys_i), .acc_valid_o(acc_valid), .acc_write_o(acc_write),
        .acc_el_o(acc_el), .acc_ns_o(acc_ns), .acc_op1_o(acc_op1), .acc_crn_o(acc_crn),
        .acc_crm_o(acc_crm), .acc_op2_o(acc_op2), .acc_wdata_o(acc_wdata),
        .act_valid_o(act_valid), .act_grp1_o(act_grp1), .act_prio_o(act_prio),
        .drop_valid_o(drop_valid), .drop_grp1_o(drop_grp1), .eoi_miss_o(eoi_miss));
    vih_ctrl #(.EL2_PRESENT(1'b1)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .acc_valid_i(acc_valid), .acc_write_i(acc_write), .acc_el_i(acc_el), .acc_ns_i(acc_ns),
        .acc_op1_i(acc_op1), .acc_crn_i(acc_crn), .acc_crm_i(acc_crm), .acc_op2_i(acc_op2),
        .acc_wdata_i(acc_wdata), .act_valid_i(act_valid), .act_grp1_i(act_grp1),
        .act_prio_i(act_prio), .drop_valid_i(drop_valid), .drop_grp1_i(drop_grp1),
        .eoi_miss_i(eoi_miss), .acc_done_o(done), .acc_rdata_o(rdata), .acc_undef_o(undef),
        .acc_trap_o(trap), .virt_if_enable_o(virt_en), .maint_irq_o(maint));
    // second copy without the hypervisor level, watched on its read data only
    vih_ctrl #(.EL2_PRESENT(1'b0)) dut_nh (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .acc_valid_i(acc_valid), .acc_write_i(acc_write), .acc_el_i(acc_el), .acc_ns_i(acc_ns),
        .acc_op1_i(acc_op1), .acc_crn_i(acc_crn), .acc_crm_i(acc_crm), .acc_op2_i(acc_op2),
        .acc_wdata_i(acc_wdata), .act_valid_i(act_valid), .act_grp1_i(act_grp1),
        .act_prio_i(act_prio), .drop_valid_i(drop_valid), .drop_grp1_i(drop_grp1),
        .eoi_miss_i(eoi_miss), .acc_done_o(), .acc_rdata_o(nh_rdata), .acc_undef_o(),
        .acc_trap_o(), .virt_if_enable_o(), .maint_irq_o());
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    function automatic logic [31:0] exp_rd(input int i);
        case (i)
            0: return m_ap0;
            1: return m_ap1;
            2: return m_hcr;
            3: return 32'h90280003;
            4: return m_vmcr | 32'h00000008;
            default: return m_lr[i-5];
        endcase
    endfunction
    function automatic logic exp_maint();
        logic np;
        int nv;
        np = 1'b1;
        nv = 0;
        for (int i = 0; i < 4; i++) begin
            if (m_lr[i][28]) np = 1'b0;
            if (m_lr[i][28] | m_lr[i][29]) nv++;
        end
        return m_hcr[0] & ((m_hcr[7] & !m_vmcr[1]) | (m_hcr[6] & m_vmcr[1])
            | (m_hcr[5] & !m_vmcr[0]) | (m_hcr[4] & m_vmcr[0]) | (m_hcr[3] & np)
            | (m_hcr[2] & (m_hcr[31:27] != 5'h00)) | (m_hcr[1] & (nv <= 1)));
    endfunction
    task automatic acc(input logic w, input logic [1:0] el, input logic ns,
                       input logic [2:0] op1, input logic [3:0] crm, input logic [2:0] op2,
                       input logic [31:0] d);
        core.access(w, el, ns, op1, crm, op2, d);
        r_data = rdata;
        r_nh = nh_rdata;
        r_undef = undef;
        r_trap = trap;
        `CHK(done, 1'b1)
        `CHK(virt_en, m_hcr[0])
        @(negedge clk_sys_i);
        `CHK(maint, exp_maint())
    endtask
    task automatic wr(input int i, input logic [31:0] d);
        case (i)
            0: m_ap0 = d;
            1: m_ap1 = d;
            2: m_hcr = d & 32'hF8005CFF;
            3: ;
            4: m_vmcr = d & 32'hFFFC0213;
            default: m_lr[i-5] = d;
        endcase
        acc(1'b1, vih_pkg::EL2, 1'b1, vih_pkg::OP1_HYP, t_crm[i], t_op2[i], d);
    endtask
    task automatic rd(input int i);
        acc(1'b0, vih_pkg::EL2, 1'b1, vih_pkg::OP1_HYP, t_crm[i], t_op2[i], 32'h00000000);
    endtask
    task automatic ev(input int k, input logic g, input logic [7:0] p);
        if (m_hcr[0] && k == 0 && g) m_ap1[p[7:3]] = 1'b1;
        if (m_hcr[0] && k == 0 && !g) m_ap0[p[7:3]] = 1'b1;
        if (m_hcr[0] && k == 1 && g) m_ap1 = m_ap1 & (m_ap1 - 32'h1);
        if (m_hcr[0] && k == 1 && !g) m_ap0 = m_ap0 & (m_ap0 - 32'h1);
        if (k == 2) m_hcr[31:27] = m_hcr[31:27] + 5'h01;
        core.pulse(3'b001 << k, g, p);
        @(negedge clk_sys_i);
        `CHK(maint, exp_maint())
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        rst_n_i = 1'b0;
        {m_ap0, m_ap1, m_hcr} = '0;
        m_vmcr = 32'h004C0000;
        m_lr = '{default: 32'h0};
        repeat (16) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        for (int i = 0; i < 9; i++) begin
            rd(i);
            `CHK(r_data, exp_rd(i))
        end
        for (int n = 0; n < 48; n++) begin
            idx = {$random(seed)} % 9;
            wr(idx, $random(seed));
            rd(idx);
            `CHK(r_data, exp_rd(idx))
        end
        for (int op = 4; op < 8; op++) begin
            acc(1'b0, vih_pkg::EL2, 1'b1, vih_pkg::OP1_HYP, 4'hC, op[2:0], 32'h0);
            `CHK(r_undef, 1'b1)
        end
        for (int k = 0; k < 4; k++) begin
            wr(2, 32'h1 << g_bit[k]);
            acc(k == 3, vih_pkg::EL1, 1'b1, vih_pkg::OP1_GUEST, g_crm[k], g_op2[k], 32'h0);
            `CHK(r_trap, 1'b1)
            acc(k == 3, vih_pkg::EL1, 1'b0, vih_pkg::OP1_GUEST, g_crm[k], g_op2[k], 32'h0);
            `CHK(r_trap, 1'b0)
            wr(2, 32'h00002000);
            acc(k == 3, vih_pkg::EL1, 1'b1, vih_pkg::OP1_GUEST, g_crm[k], g_op2[k], 32'h0);
            `CHK(r_trap, 1'b0)
        end
        wr(0, 32'h0);
        wr(1, 32'h0);
        wr(2, 32'h00000005);
        for (int j = 0; j < 24; j++) begin
            if (j == 18) wr(2, exp_rd(2) & 32'hFFFFFFFE);
            idx = {$random(seed)} % 3;
            ev(idx, j[0], $random(seed));
            rd(j[0]);
            `CHK(r_data, exp_rd(j[0]))
        end
        m_ap1 = 32'hA5A5A5A5;
        acc(1'b1, vih_pkg::EL3, 1'b0, vih_pkg::OP1_HYP, 4'h9, 3'h0, 32'hA5A5A5A5);
        acc(1'b0, vih_pkg::EL3, 1'b0, vih_pkg::OP1_HYP, 4'h9, 3'h0, 32'h00000000);
        `CHK(r_data, m_ap1)
        `CHK(r_nh, 32'h00000000)
        acc(1'b0, vih_pkg::EL3, 1'b0, vih_pkg::OP1_HYP, 4'hB, 3'h1, 32'h00000000);
        `CHK(r_nh, 32'h00100000)
        rd(2);
        `CHK(r_data, exp_rd(2))
        end_of_test();
    end
endmodule
